// ==== logic/startup_seq_pkg.sv ====
package startup_seq_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned RELEASE_DELAY_US = 500;
  localparam int unsigned RELEASE_DELAY_CYC = RELEASE_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DLY_W = 20;

  // ---------------------------------------------------------------
  // Register map (word offsets in bytes)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COND = 4'h8;

  // Control register fields
  localparam int unsigned CTRL_MOD_EN_BIT = 4;
  localparam int unsigned CTRL_DIG_IN_BIT = 0;
  localparam int unsigned CTRL_SINGLE_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Tristate-command source selected by the mode pins
  typedef enum logic [1:0] {
    MODE_NOBUS = 2'b00,
    MODE_BUS = 2'b01,
    MODE_NOBUS_DIAG = 2'b10
  } bus_mode_t;

  // Comparator flags from the analog monitors, one bit each, high = satisfied
  typedef struct packed {
    logic upper_drop_ok;
    logic lower_drop_ok;
    logic below_upper_limit;
    logic below_upper_limit_abs;
    logic above_poweron;
    logic ripple_ref_ok;
    logic rail14_ok;
  } supply_flags_t;

  // Events that force tristate
  typedef struct packed {
    logic diag_active;
    logic offset_det;
    logic overcurrent2;
  } fault_flags_t;

endpackage

// ==== logic/release_delay.sv ====
// ---------------------------------------------------------------
// Qualification timer: done after CYCLES of uninterrupted run_i
// ---------------------------------------------------------------
module release_delay
  import startup_seq_pkg::*;
#(
  parameter int unsigned CYCLES = RELEASE_DELAY_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic done_o
);

  logic [DLY_W-1:0] cnt_r;

  // Restart on any drop of the conditions
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (!run_i) begin
      cnt_r <= '0;
    end else if (cnt_r != DLY_W'(CYCLES)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign done_o = run_i && (cnt_r == DLY_W'(CYCLES));

endmodule

// ==== logic/modulator_startup_sequencer.sv ====
// Notes on behaviour
// - Modulator stays tristate unless mode pin, command, thermal flag and supplies all hold.
// - PLL lock counts only when the digital input path is selected.
// - All seven supply comparator flags must be satisfied before release.
// - Without bus or diagnostic, command goes to one once digital supply settles.
// - In bus mode, command needs settled supply and host-written enable bit.
// - In no-bus diagnostic mode, command needs settled supply and fault-free diagnostic.
// - Thermal flag starts at one, clears on either second temperature threshold.
// - At start-up, release follows about 500 us after all conditions hold.
// - Split supply: after diagnostic tristate, resume 500 us after conditions return.
// - Single supply: block reference charge and release while reference exceeds 1.5 V.
// - Single supply: after tristate wait discharge below 1.5 V, recharge, then delay.
// - Diagnostic, offset or second overcurrent threshold force tristate.
//
// Added by the designer: the register offsets and the address-and-strobe port.
module modulator_startup_sequencer
  import startup_seq_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = RELEASE_DELAY_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic mode_level_pin_a_i,
  input wire logic mode_level_pin_b_i,
  input wire logic [1:0] bus_mode_i,
  input wire logic digital_supply_ok_i,
  input wire logic diag_done_i,
  input wire logic diag_fault_i,
  input wire logic pll_lock_i,
  input wire logic int_temp_thr2_i,
  input wire logic ext_temp_thr2_i,
  input wire supply_flags_t supply_i,
  input wire fault_flags_t fault_i,
  input wire logic ref_above_1v5_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic modulator_en_o,
  output logic ref_charge_en_o
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic thermal_ok_r;
  logic release_cmd_r;
  logic conds_ok;
  logic done;
  logic mod_en_r;
  logic charge_en_r;
  logic [7:0] rdata_r;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_i && addr_i == ADDR_CTRL) begin
      ctrl_r <= wdata_i;
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CTRL: rdata_r <= ctrl_r;
        ADDR_STATUS: rdata_r <= {4'h0, charge_en_r, thermal_ok_r, release_cmd_r, mod_en_r};
        ADDR_COND: rdata_r <= {conds_ok, supply_i};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata_o = rdata_r;

  // ---------------------------------------------------------------
  // Internal tristate command
  // ---------------------------------------------------------------
  logic cmd_nxt;

  always_comb begin
    case (bus_mode_t'(bus_mode_i))
      MODE_NOBUS: cmd_nxt = digital_supply_ok_i;
      MODE_BUS: cmd_nxt = digital_supply_ok_i && ctrl_r[CTRL_MOD_EN_BIT];
      MODE_NOBUS_DIAG: cmd_nxt = digital_supply_ok_i && diag_done_i && !diag_fault_i;
      default: cmd_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      release_cmd_r <= 1'b0;
    end else begin
      release_cmd_r <= cmd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Thermal flag
  // ---------------------------------------------------------------
  // Latched low: only a fresh start-up brings it back
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      thermal_ok_r <= 1'b1;
    end else if (int_temp_thr2_i || ext_temp_thr2_i) begin
      thermal_ok_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Reference capacitor restart for single supply
  // ---------------------------------------------------------------
  logic single;
  assign single = ctrl_r[CTRL_SINGLE_BIT];

  // Charge drops with the modulator and restarts only once the cap is below 1.5 V
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      charge_en_r <= 1'b0;
    end else if (!single) begin
      charge_en_r <= 1'b1;
    end else if (mod_en_r && !conds_ok) begin
      charge_en_r <= 1'b0;
    end else if (!charge_en_r && !ref_above_1v5_i) begin
      charge_en_r <= 1'b1;
    end
  end

  assign ref_charge_en_o = charge_en_r;

  // ---------------------------------------------------------------
  // Enable conditions and release
  // ---------------------------------------------------------------
  logic pll_ok;
  logic fault_any;
  assign pll_ok = !ctrl_r[CTRL_DIG_IN_BIT] || pll_lock_i;
  assign fault_any = |fault_i;

  always_comb begin
    conds_ok = (mode_level_pin_a_i || mode_level_pin_b_i) && release_cmd_r
               && thermal_ok_r && pll_ok && (&supply_i) && !fault_any
               && (!single || charge_en_r);
  end

  release_delay #(
    .CYCLES(DELAY_CYCLES)
  ) u_delay (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .run_i(conds_ok),
    .done_o(done)
  );

  // Same delay after start-up and after any tristate event
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mod_en_r <= 1'b0;
    end else if (!conds_ok) begin
      mod_en_r <= 1'b0;
    end else if (done) begin
      mod_en_r <= 1'b1;
    end
  end

  assign modulator_en_o = mod_en_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_fault_forces_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    fault_any |=> !mod_en_r) else $error("modulator on during fault");
  a_lost_cond_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !conds_ok |=> !mod_en_r) else $error("modulator on without conditions");
  a_no_early_release: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(mod_en_r) |-> $past(done)) else $error("release without delay");
  a_thermal_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (int_temp_thr2_i || ext_temp_thr2_i) |=> !thermal_ok_r ##1 !mod_en_r)
    else $error("thermal flag not cleared");
  a_bus_cmd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_mode_i == MODE_BUS && !ctrl_r[CTRL_MOD_EN_BIT]) |=> !release_cmd_r)
    else $error("command set without enable bit");
  a_diag_cmd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_mode_i == MODE_NOBUS_DIAG && diag_fault_i) |=> !release_cmd_r)
    else $error("command set despite diagnostic fault");
  a_nobus_cmd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_mode_i == MODE_NOBUS && digital_supply_ok_i) |=> release_cmd_r)
    else $error("command not set on settled supply");
  a_pll_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ctrl_r[CTRL_DIG_IN_BIT] && !pll_lock_i) |=> !mod_en_r)
    else $error("release without pll lock");
  a_supply_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !(&supply_i) |=> !mod_en_r) else $error("release with supply out of range");
  a_ref_block: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (single && !charge_en_r && ref_above_1v5_i) |=> !charge_en_r && !mod_en_r)
    else $error("charge restarted above 1.5 V");
  a_ref_restart: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (single && mod_en_r && !conds_ok) |=> !charge_en_r)
    else $error("charge kept after tristate event");
  a_mode_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !(mode_level_pin_a_i || mode_level_pin_b_i) |=> !mod_en_r)
    else $error("release without mode pin");
  a_stays_on: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (mod_en_r && conds_ok) |=> mod_en_r) else $error("modulator dropped with conditions ok");

  // ---------------------------------------------------------------
  // Checker helpers
  // ---------------------------------------------------------------
  // Counts edges with all conditions held, saturating one past the delay, so that
  // the release timing can be checked without a long repetition in a property
  localparam logic [DLY_W:0] RUN_FULL = (DLY_W + 1)'(DELAY_CYCLES + 1);
  logic [DLY_W:0] ok_run_r;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ok_run_r <= '0;
    end else if (!conds_ok) begin
      ok_run_r <= '0;
    end else if (ok_run_r != RUN_FULL) begin
      ok_run_r <= ok_run_r + 1'b1;
    end
  end

  a_release_timing: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(mod_en_r) |-> ok_run_r == RUN_FULL) else $error("release at wrong cycle");
  a_release_late: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ok_run_r == RUN_FULL && conds_ok) |-> mod_en_r) else $error("release missing after delay");
  a_illegal_mode: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bus_mode_i == 2'b11) |=> !release_cmd_r) else $error("command set in illegal mode");
  a_thermal_sticky: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !thermal_ok_r |=> !thermal_ok_r) else $error("thermal flag returned without reset");
  a_split_charge: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !single |=> charge_en_r) else $error("charge blocked in split supply");
  a_ctrl_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_i && addr_i == ADDR_CTRL) |=> ctrl_r == $past(wdata_i))
    else $error("control write lost");
  a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !rd_i |=> rdata_r == 8'h00) else $error("read data without read");
  a_ctrl_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == ADDR_CTRL) |=> rdata_r == $past(ctrl_r))
    else $error("control read wrong");
  a_status_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == ADDR_STATUS) |=> rdata_r[0] == $past(mod_en_r)
    && rdata_r[2] == $past(thermal_ok_r)) else $error("status read wrong");
  a_cond_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (rd_i && addr_i == ADDR_COND) |=> rdata_r == {$past(conds_ok), $past(supply_i)})
    else $error("condition read wrong");

  c_release: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(mod_en_r));
  c_fault_trip: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    mod_en_r && fault_any);
  c_single_restart: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    single && $rose(charge_en_r));
  c_thermal_trip: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    $fell(thermal_ok_r));

endmodule

// ==== verif/monitor_model.sv ====
module monitor_model
  import startup_seq_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic charge_en_i,
  input wire logic [7:0] sag_i,
  output supply_flags_t supply_o,
  output logic ref_above_1v5_o
);
  // ---------------------------------------------------------------
  // Ripple reference ramps one step a cycle, so a discharge is slow
  // ---------------------------------------------------------------
  logic [2:0] lvl_r;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) lvl_r <= 3'h0;
    else if (charge_en_i && lvl_r != 3'h7) lvl_r <= lvl_r + 3'h1;
    else if (!charge_en_i && lvl_r != 3'h0) lvl_r <= lvl_r - 3'h1;
  end
  assign ref_above_1v5_o = lvl_r > 3'h3;
  always_comb begin
    supply_o = 7'h7F;
    supply_o.ripple_ref_ok = lvl_r > 3'h4;
    if (sag_i < 8'h07) supply_o[sag_i[2:0]] = 1'b0;
  end
endmodule

// ==== verif/modulator_startup_sequencer_tb.sv ====
module modulator_startup_sequencer_tb import startup_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Short delay keeps the run small
  // ---------------------------------------------------------------
  localparam int unsigned D = 10;
  logic clk = 1'b0, rst = 1'b1, pa = 1'b1, pb = 1'b0, dsup = 1'b0;
  logic ddone = 1'b0, dfault = 1'b0, pll = 1'b1, tint = 1'b0, text = 1'b0;
  logic wr = 1'b0, rd = 1'b0, en, chg, ref_hi;
  logic [1:0] bmode = 2'b00;
  logic [7:0] sag = 8'hFF, wdata = 8'h00, rdata;
  logic [3:0] addr = 4'h0;
  fault_flags_t flt = 3'h0;
  supply_flags_t sup;
  int n_errors = 0, comparisons = 0, cyc = 0;
  always #2 clk = ~clk;
  monitor_model model (.clk_sys_i(clk), .rst_i(rst), .charge_en_i(chg), .sag_i(sag),
    .supply_o(sup), .ref_above_1v5_o(ref_hi));
  modulator_startup_sequencer #(.DELAY_CYCLES(D)) dut (.clk_sys_i(clk), .rst_i(rst),
    .mode_level_pin_a_i(pa), .mode_level_pin_b_i(pb), .bus_mode_i(bmode),
    .digital_supply_ok_i(dsup), .diag_done_i(ddone), .diag_fault_i(dfault),
    .pll_lock_i(pll), .int_temp_thr2_i(tint), .ext_temp_thr2_i(text), .supply_i(sup),
    .fault_i(flt), .ref_above_1v5_i(ref_hi), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .modulator_en_o(en), .ref_charge_en_o(chg));
  function automatic logic [7:0] status(input logic c, t, r, e);
    return {4'h0, c, t, r, e};
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Counts edges from the input change to the release
  task automatic wait_en(output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (en !== 1'b1 && n < 300);
  endtask
  task automatic set_cond(input int i, input logic on);
    @(posedge clk);
    if (i < 7) sag <= on ? 8'hFF : 8'(i);
    else if (i < 10) flt <= on ? 3'h0 : 3'(1 << (i - 7));
    else if (i == 10) pa <= on;
    else pll <= on;
  endtask
  initial begin
    int n;
    logic [7:0] d;
    n = $urandom(36);
    tick(16);
    rst <= 1'b0;
    rd_reg(ADDR_STATUS, d);
    check("status", d, status(1, 1, 0, 0));
    tick(1);
    check("rdata idle", rdata, 8'h00);
    rd_reg(ADDR_CTRL, d);
    check("ctrl", d, CTRL_RESET);
    rd_reg(4'hC, d);
    check("unmapped", d, 8'h00);
    tick(20);
    check("en early", en, 1'b0);
    @(posedge clk);
    dsup <= 1'b1;
    wait_en(n);
    check("start delay", n, D + 2);
    $display("test startup done");
    wr_reg(ADDR_CTRL, 8'h01);
    for (int i = 0; i < 12; i++) begin
      set_cond(i, 0);
      tick(2);
      check("drop", en, 1'b0);
      tick($urandom % 8);
      set_cond(i, 1);
      tick(1 + $urandom % (D - 1));
      set_cond(i, 0);
      set_cond(i, 1);
      wait_en(n);
      check("restart", n, D + 1);
    end
    wr_reg(ADDR_CTRL, 8'h00);
    set_cond(11, 0);
    tick(D + 5);
    check("pll ignored", en, 1'b1);
    set_cond(11, 1);
    bmode <= 2'b11;
    tick(D + 5);
    check("illegal mode", en, 1'b0);
    $display("test conditions done");
    bmode <= 2'b01;
    tick(D + 5);
    check("bus no bit", en, 1'b0);
    wr_reg(ADDR_CTRL, 8'h10);
    wr_reg(4'hC, 8'($urandom));
    rd_reg(ADDR_CTRL, d);
    check("ctrl kept", d, 8'h10);
    tick(D + 5);
    check("bus bit", en, 1'b1);
    rd_reg(ADDR_COND, d);
    check("cond all ok", d, 8'hFF);
    bmode <= 2'b10;
    dfault <= 1'b1;
    tick(D + 5);
    check("diag pending", en, 1'b0);
    ddone <= 1'b1;
    tick(D + 5);
    check("diag fault", en, 1'b0);
    dfault <= 1'b0;
    tick(D + 5);
    check("diag pass", en, 1'b1);
    $display("test modes done");
    bmode <= 2'b00;
    wr_reg(ADDR_CTRL, 8'h02);
    set_cond(0, 0);
    set_cond(0, 1);
    tick(2);
    check("charge held", {en, chg, ref_hi}, 3'b001);
    wait_en(n);
    check("recharge", n > D + 4 && en === 1'b1, 1'b1);
    $display("test single supply done");
    tint <= 1'b1;
    tick(1);
    tint <= 1'b0;
    tick(D + 5);
    check("thermal int", en, 1'b0);
    rd_reg(ADDR_STATUS, d);
    check("thermal bit", d[2], 1'b0);
    rst <= 1'b1;
    tick(2);
    check("reset", {en, chg}, 2'b00);
    rst <= 1'b0;
    tick(40);
    check("after reset", en, 1'b1);
    text <= 1'b1;
    tick(3);
    check("thermal ext", en, 1'b0);
    $display("test thermal done");
    end_sim();
  end
endmodule
